/* rtl/adcc_pkg.sv */
// Function
// [RL1] changing alignment re-presents the held result at once
// [RL2] left alignment: result 9..2 high byte, 1..0 in low bits 7..6
// [RL3] right alignment (default): 7..0 low byte, 9..8 in high bits 1..0
// [RL4] input select change waits until the running conversion completes
// [RL5] codes 0-7 single-ended inputs, 11110 bandgap, 11111 ground
// [RL6] codes 10000-10111 against input 1, 11000-11101 against input 2
// [RL7] enable powers converter; clearing it aborts a running conversion
// [RL8] single mode needs a start per conversion; free running only first
// [RL9] first conversion after enabling takes 25 converter cycles, else 13
// [RL10] start bit reads one while busy; writing zero does nothing
// [RL11] auto-trigger starts a conversion on the selected trigger's rising edge
// [RL12] flag set on completion; interrupt when flag, enable, global all one
// [RL13] flag cleared by interrupt vectoring or by writing one to it
// [RL14] software avoids read-modify-write on control register A
// [RL15] divider codes 000/001 by 2 up to 111 by 128
// [RL16] low byte read holds result until high byte read
// [RL17] left-aligned eight-bit users may read only the high byte
// [RL18] reference select change waits until the running conversion completes
// [RL19] trigger source zero is free running; switching to it never triggers
// [RL20] free running restarts immediately after each completion while enabled
// [RL21] start bit also reads one for auto-triggered conversions
package adcc_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] ADCC_IDX_RES_LOW = 10'h078;
  localparam logic [9:0] ADCC_IDX_RES_HIGH = 10'h079;
  localparam logic [9:0] ADCC_IDX_CTRL_A = 10'h07a;
  localparam logic [9:0] ADCC_IDX_CTRL_B = 10'h07b;
  localparam logic [9:0] ADCC_IDX_MUX = 10'h07c;
  // control register a fields
  localparam int ADCC_A_POWER = 7;
  localparam int ADCC_A_START = 6;
  localparam int ADCC_A_AUTO = 5;
  localparam int ADCC_A_DONE = 4;
  localparam int ADCC_A_IRQ_EN = 3;
  // mux register fields
  localparam int ADCC_M_LEFT = 5;
  // reset values
  localparam logic [7:0] ADCC_RST_CTRL_A = 8'h00;
  localparam logic [7:0] ADCC_RST_MUX = 8'h00;
  localparam logic [2:0] ADCC_RST_TRIG_SRC = 3'h0;
  // conversion lengths in converter clock cycles
  localparam logic [4:0] ADCC_FIRST_CYCLES = 5'd25;
  localparam logic [4:0] ADCC_NORMAL_CYCLES = 5'd13;
  // special input select codes and the free-running trigger source
  localparam logic [4:0] ADCC_SEL_BANDGAP = 5'h1e;
  localparam logic [4:0] ADCC_SEL_GROUND = 5'h1f;
  localparam logic [2:0] ADCC_TRIG_FREE = 3'h0;
  // analog source selection kinds
  typedef enum logic [1:0] {
    ADCC_SRC_PIN = 2'b00,
    ADCC_SRC_BANDGAP = 2'b01,
    ADCC_SRC_GROUND = 2'b10,
    ADCC_SRC_NONE = 2'b11
  } adcc_src_t;
  // converter sequencing states
  typedef enum logic [1:0] {
    ADCC_OFF = 2'b00,
    ADCC_IDLE = 2'b01,
    ADCC_BUSY = 2'b10
  } adcc_state_t;
endpackage

/* rtl/adcc_prescaler.sv */
`timescale 1ns/10ps
module adcc_prescaler
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // control
  input wire logic run,
  input wire logic [2:0] divider_select,
  // converter clock tick
  output logic tick
);
  logic [6:0] count;
  logic [6:0] limit;

  // [RL15] divide factor table
  always_comb
  begin
    case (divider_select)
      3'h0, 3'h1: limit = 7'h01;
      3'h2: limit = 7'h03;
      3'h3: limit = 7'h07;
      3'h4: limit = 7'h0f;
      3'h5: limit = 7'h1f;
      3'h6: limit = 7'h3f;
      default: limit = 7'h7f;
    endcase
  end

  // held at zero when stopped so each conversion starts on a full period
  always_ff @(posedge clock)
  begin
    if (!reset_n || !run)
      count <= 7'h00;
    else if (count >= limit)
      count <= 7'h00;
    else
      count <= count + 7'h01;
  end

  assign tick = run && (count >= limit);
endmodule

/* rtl/adcc_edge.sv */
`timescale 1ns/10ps
module adcc_edge
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // level in, rising edge out
  input wire logic level,
  output logic rise
);
  logic last;

  // previous level; source is same-clock logic, so no synchroniser
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      last <= 1'b0;
    else
      last <= level;
  end

  assign rise = level && !last;
endmodule

/* rtl/adcc_top.sv */
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
module adcc_top
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger sources, index 1..7 used, same clock domain
  input wire logic [7:1] trigger_sources,
  // processor interrupt side
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  output logic conversion_irq,
  // analog front end
  output logic converter_power,
  output logic conversion_active,
  output logic [1:0] active_reference,
  output adcc_src_t active_source,
  output logic [2:0] positive_input,
  output logic [2:0] negative_input,
  output logic differential_mode,
  input wire logic [9:0] analog_result
);
  adcc_state_t state;
  logic power_on;
  logic auto_trigger_on;
  logic done_flag;
  logic irq_enable;
  logic [2:0] clock_divider_select;
  logic [2:0] trigger_source_select;
  logic [1:0] reference_select;
  logic result_left_align;
  logic [4:0] input_select;
  logic [4:0] active_select;
  logic [9:0] conversion_result;
  logic result_locked;
  logic init_pending;
  logic [4:0] cycle_count;
  logic [4:0] cycle_target;
  logic adc_tick;
  logic trig_level;
  logic trig_rise;
  logic setup;
  logic access;
  logic mapped;
  logic [9:0] index;
  logic wr_a;
  logic wr_b;
  logic wr_mux;
  logic rd_low;
  logic rd_high;
  logic sw_start;
  logic start_now;
  logic finish;
  logic [7:0] res_low;
  logic [7:0] res_high;
  logic [7:0] rd_value;

  // bus decode; one setup and one access cycle per transfer
  assign index = paddr[11:2];
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr[1:0] == 2'b00) &&
                  (index == ADCC_IDX_RES_LOW || index == ADCC_IDX_RES_HIGH ||
                   index == ADCC_IDX_CTRL_A || index == ADCC_IDX_CTRL_B ||
                   index == ADCC_IDX_MUX);
  assign pready = access;
  assign pslverr = access && !mapped;
  assign wr_a = access && pwrite && mapped && index == ADCC_IDX_CTRL_A;
  assign wr_b = access && pwrite && mapped && index == ADCC_IDX_CTRL_B;
  assign wr_mux = access && pwrite && mapped && index == ADCC_IDX_MUX;
  assign rd_low = access && !pwrite && mapped && index == ADCC_IDX_RES_LOW;
  assign rd_high = access && !pwrite && mapped && index == ADCC_IDX_RES_HIGH;

  // [RL1] presentation follows the live alignment bit, not the capture
  always_comb
  begin
    if (result_left_align)
    begin
      // [RL2] left aligned layout
      res_high = conversion_result[9:2];
      res_low = {conversion_result[1:0], 6'h00};
    end
    else
    begin
      // [RL3] right aligned layout
      res_high = {6'h00, conversion_result[9:8]};
      res_low = conversion_result[7:0];
    end
  end

  // read mux
  always_comb
  begin
    case (index)
      ADCC_IDX_RES_LOW: rd_value = res_low;
      ADCC_IDX_RES_HIGH: rd_value = res_high;
      // [RL10] [RL21] start bit reads the busy state for every conversion
      ADCC_IDX_CTRL_A: rd_value = {power_on, state == ADCC_BUSY,
        auto_trigger_on, done_flag, irq_enable, clock_divider_select};
      ADCC_IDX_CTRL_B: rd_value = {5'h00, trigger_source_select};
      ADCC_IDX_MUX: rd_value = {reference_select, result_left_align,
        input_select};
      default: rd_value = 8'h00;
    endcase
  end

  // read data captured in setup so it comes from a flip-flop
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite && mapped)
      prdata <= {24'h00_0000, rd_value};
    else if (setup)
      prdata <= 32'h0000_0000;
  end

  // control register a writable fields
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      power_on <= ADCC_RST_CTRL_A[ADCC_A_POWER];
      auto_trigger_on <= ADCC_RST_CTRL_A[ADCC_A_AUTO];
      irq_enable <= ADCC_RST_CTRL_A[ADCC_A_IRQ_EN];
      clock_divider_select <= ADCC_RST_CTRL_A[2:0];
    end
    else if (wr_a)
    begin
      // [RL7] enable bit powers the converter
      power_on <= pwdata[ADCC_A_POWER];
      auto_trigger_on <= pwdata[ADCC_A_AUTO];
      irq_enable <= pwdata[ADCC_A_IRQ_EN];
      clock_divider_select <= pwdata[2:0];
    end
  end

  // control register b and mux register
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      trigger_source_select <= ADCC_RST_TRIG_SRC;
      reference_select <= ADCC_RST_MUX[7:6];
      result_left_align <= ADCC_RST_MUX[ADCC_M_LEFT];
      input_select <= ADCC_RST_MUX[4:0];
    end
    else
    begin
      if (wr_b)
        trigger_source_select <= pwdata[2:0];
      if (wr_mux)
      begin
        reference_select <= pwdata[7:6];
        result_left_align <= pwdata[ADCC_M_LEFT];
        input_select <= pwdata[4:0];
      end
    end
  end

  // [RL19] source zero selects a constant low, so switching to it never rises
  assign trig_level = (trigger_source_select == ADCC_TRIG_FREE) ? 1'b0 :
                      trigger_sources[trigger_source_select];

  adcc_edge u_trig_edge (
    .clock(clock),
    .reset_n(reset_n),
    .level(trig_level),
    .rise(trig_rise)
  );

  // [RL10] only a written one starts; a written zero leaves state alone
  assign sw_start = wr_a && pwdata[ADCC_A_START] && pwdata[ADCC_A_POWER];

  // start request while idle; triggers arriving mid-conversion are dropped
  always_comb
  begin
    start_now = 1'b0;
    if (power_on || sw_start)
    begin
      // [RL8] software start for each single conversion
      if (sw_start)
        start_now = 1'b1;
      // [RL11] rising trigger edge with auto-trigger on
      if (power_on && auto_trigger_on && trig_rise &&
          trigger_source_select != ADCC_TRIG_FREE)
        start_now = 1'b1;
    end
  end

  adcc_prescaler u_prescaler (
    .clock(clock),
    .reset_n(reset_n),
    .run(state == ADCC_BUSY),
    .divider_select(clock_divider_select),
    .tick(adc_tick)
  );

  // [RL9] longer first conversion performs initialization
  assign finish = state == ADCC_BUSY && adc_tick &&
                  cycle_count == cycle_target - 5'd1;

  // conversion sequencer
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state <= ADCC_OFF;
      cycle_count <= 5'd0;
      cycle_target <= ADCC_NORMAL_CYCLES;
      init_pending <= 1'b0;
    end
    else
    begin
      case (state)
        ADCC_OFF:
        begin
          cycle_count <= 5'd0;
          if (wr_a && pwdata[ADCC_A_POWER])
          begin
            // [RL9] start written together with enable counts as first
            init_pending <= 1'b1;
            if (sw_start)
            begin
              state <= ADCC_BUSY;
              cycle_target <= ADCC_FIRST_CYCLES;
              init_pending <= 1'b0;
            end
            else
              state <= ADCC_IDLE;
          end
        end
        ADCC_IDLE:
        begin
          cycle_count <= 5'd0;
          if (wr_a && !pwdata[ADCC_A_POWER])
            state <= ADCC_OFF;
          else if (start_now)
          begin
            state <= ADCC_BUSY;
            cycle_target <= init_pending ? ADCC_FIRST_CYCLES :
                            ADCC_NORMAL_CYCLES;
            init_pending <= 1'b0;
          end
        end
        ADCC_BUSY:
        begin
          // [RL7] disabling before the finishing cycle aborts the conversion, no result, no flag
          if (wr_a && !pwdata[ADCC_A_POWER])
            state <= ADCC_OFF;
          else if (finish)
          begin
            cycle_count <= 5'd0;
            cycle_target <= ADCC_NORMAL_CYCLES;
            // [RL20] free running chains the next conversion at once
            if (!(auto_trigger_on &&
                  trigger_source_select == ADCC_TRIG_FREE))
              state <= ADCC_IDLE;
          end
          else if (adc_tick)
            cycle_count <= cycle_count + 5'd1;
        end
        default:
          state <= ADCC_OFF;
      endcase
    end
  end

  // [RL4] [RL18] selections latch only while no conversion runs or in the cycle one finishes
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      active_select <= ADCC_RST_MUX[4:0];
      active_reference <= ADCC_RST_MUX[7:6];
    end
    else if (state != ADCC_BUSY || finish)
    begin
      active_select <= input_select;
      active_reference <= reference_select;
    end
  end

  // [RL5] [RL6] decode of the latched input select code
  always_comb
  begin
    positive_input = active_select[2:0];
    negative_input = 3'h0;
    differential_mode = 1'b0;
    active_source = ADCC_SRC_PIN;
    if (active_select == ADCC_SEL_BANDGAP)
      active_source = ADCC_SRC_BANDGAP;
    else if (active_select == ADCC_SEL_GROUND)
      active_source = ADCC_SRC_GROUND;
    else if (active_select[4:3] == 2'b01)
      active_source = ADCC_SRC_NONE;
    else if (active_select[4])
    begin
      differential_mode = 1'b1;
      negative_input = active_select[3] ? 3'h2 : 3'h1;
    end
  end

  // [RL16] low byte read locks the result until the high byte is read
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      result_locked <= 1'b0;
    else if (rd_high)
      result_locked <= 1'b0;
    else if (rd_low)
      result_locked <= 1'b1;
  end

  // result capture; a result finished while locked is lost
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      conversion_result <= 10'h000;
    else if (finish && !result_locked)
      conversion_result <= analog_result;
  end

  // [RL12] [RL13] done flag; set wins over either clear
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      done_flag <= ADCC_RST_CTRL_A[ADCC_A_DONE];
    else if (finish)
      done_flag <= 1'b1;
    else if (irq_vector_taken || (wr_a && pwdata[ADCC_A_DONE]))
      done_flag <= 1'b0;
  end

  // [RL12] interrupt request
  assign conversion_irq = done_flag && irq_enable && global_irq_enable;

  // analog front end status
  assign converter_power = power_on;
  assign conversion_active = state == ADCC_BUSY;
endmodule

/* sim/adcc_front_model.sv */
`timescale 1ns/10ps
module adcc_front_model
  import adcc_pkg::*;
(
  // selection seen at the pins
  input wire logic converter_power,
  input wire adcc_src_t active_source,
  input wire logic [2:0] positive_input,
  input wire logic [2:0] negative_input,
  input wire logic differential_mode,
  // level handed to the converter
  output logic [9:0] analog_result
);
  // every pick gives a value naming it, so a wrong pick shows
  // pin pairing model
  always_comb
  begin
    if (!converter_power)
      analog_result = 10'h2aa;
    else if (active_source != ADCC_SRC_PIN)
      analog_result = {active_source, 8'h00};
    else
      analog_result = {2'b00, differential_mode, positive_input,
        differential_mode ? negative_input : 3'h0, 1'b1};
  end
endmodule

/* sim/adcc_top_chk.sv */
`timescale 1ns/10ps
module adcc_top_chk
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // interrupt
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  input wire logic conversion_irq,
  // front end
  input wire logic converter_power,
  input wire logic conversion_active,
  input wire logic [1:0] active_reference,
  input wire logic [2:0] positive_input,
  input wire logic [2:0] negative_input,
  input wire logic differential_mode
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [11:0] run_cnt;
  wire wr_go = psel && penable && pwrite
    && paddr == {ADCC_IDX_CTRL_A, 2'b00}
    && pwdata[ADCC_A_POWER] && pwdata[ADCC_A_START] && !conversion_active;
  // length of the current busy stretch
  always_ff @(posedge clock)
  begin
    if (!reset_n || !conversion_active)
      run_cnt <= 12'h000;
    else
      run_cnt <= run_cnt + 12'h001;
  end
  sequence s_go;
    $rose(conversion_active);
  endsequence
  sequence s_sel_held;
    $stable({positive_input, negative_input})[*8];
  endsequence
  sequence s_ref_held;
    $stable(active_reference)[*8];
  endsequence
  a_power_abort: assert property ($fell(converter_power) |-> ##[0:1] !conversion_active)
    else $error("conversion survived power off");
  a_start_busy: assert property (wr_go |-> ##[1:2] conversion_active)
    else $error("start write did not raise busy");
  // shortest legal run is 13 converter cycles at the smallest divide of 2
  a_min_length: assert property ($fell(conversion_active) && converter_power |-> run_cnt >= 12'd26)
    else $error("conversion ended too early");
  a_irq_global: assert property (conversion_irq |-> global_irq_enable)
    else $error("interrupt without global enable");
  a_vector_clear: assert property (conversion_irq && irq_vector_taken && !conversion_active |=> !conversion_irq)
    else $error("vectoring left the flag set");
  a_diff_pairs: assert property (differential_mode |-> negative_input == 3'd1 || negative_input == 3'd2 && positive_input < 3'd6)
    else $error("illegal differential pair");
  a_sel_wait: assert property (s_go |=> s_sel_held)
    else $error("input changed during conversion");
  a_ref_wait: assert property (s_go |=> s_ref_held)
    else $error("reference changed during conversion");
endmodule

bind adcc_top adcc_top_chk chk_u (.clock, .reset_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .global_irq_enable, .irq_vector_taken,
  .conversion_irq, .converter_power, .conversion_active,
  .active_reference, .positive_input, .negative_input,
  .differential_mode);

/* sim/adcc_top_test.sv */
`timescale 1ns/10ps
module adcc_top_test
  import adcc_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:1] trigger_sources = 7'h00;
  logic global_irq_enable = 1'b0;
  logic irq_vector_taken = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, conversion_irq, converter_power;
  logic conversion_active, differential_mode, err;
  logic [1:0] active_reference;
  adcc_src_t active_source;
  logic [2:0] positive_input, negative_input;
  logic [9:0] analog_result;
  logic [7:0] rd;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int n;

  adcc_top dut_u (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .trigger_sources,
    .global_irq_enable, .irq_vector_taken, .conversion_irq,
    .converter_power, .conversion_active, .active_reference,
    .active_source, .positive_input, .negative_input,
    .differential_mode, .analog_result);
  adcc_front_model front_u (.converter_power, .active_source,
    .positive_input, .negative_input, .differential_mode,
    .analog_result);

  // system clock
  always #5 clock = ~clock;

  // hang guard, well above the longest expected run
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      finish_test();
    end
  end

  // verdict
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // compare
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [9:0] idx,
    input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do
      @(posedge clock);
    while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // edges from the start write until busy is seen low again
  task automatic measure();
    logic seen;
    seen = 1'b0;
    n = 0;
    while (!(seen && conversion_active === 1'b0) && n < 5000)
    begin
      @(posedge clock);
      n++;
      seen = seen | (conversion_active === 1'b1);
    end
  endtask

  // low byte first so the pair stays coherent
  task automatic result(output logic [15:0] r);
    apb(1'b0, ADCC_IDX_RES_LOW, 8'h00);
    r[7:0] = rd;
    apb(1'b0, ADCC_IDX_RES_HIGH, 8'h00);
    r[15:8] = rd;
  endtask

  // value the front model gives for a select code
  function automatic logic [9:0] pick(input logic [4:0] s);
    if (s == 5'h1e || s == 5'h1f)
      return {s[0] ? 2'b10 : 2'b01, 8'h00};
    // unused codes connect nothing
    if (s[4:3] == 2'b01)
      return 10'h300;
    if (!s[4])
      return {3'b000, s[2:0], 4'h1};
    return {3'b001, s[2:0], 1'b0, s[3], !s[3], 1'b1};
  endfunction

  // reset values and an unmapped place
  task automatic t_regs();
    logic [9:0] idx [6] = '{ADCC_IDX_RES_LOW, ADCC_IDX_RES_HIGH,
      ADCC_IDX_CTRL_A, ADCC_IDX_CTRL_B, ADCC_IDX_MUX, 10'h07f};
    foreach (idx[i])
    begin
      apb(1'b0, idx[i], 8'h00);
      chk(rd, 8'h00);
      chk(err, i == 5);
    end
  endtask

  // first length at divider code 0, later lengths over every divider code
  task automatic t_lengths();
    apb(1'b1, ADCC_IDX_CTRL_A, 8'hc0);
    measure();
    chk(n, 51);
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, ADCC_IDX_CTRL_A, 8'hd0 | c[7:0]);
      measure();
      chk(n, 13 * (c < 2 ? 2 : 1 << c) + 1);
      apb(1'b0, ADCC_IDX_CTRL_A, 8'h00);
      chk(rd, 8'h90 | c[7:0]);
    end
  endtask

  // every kind of input code, both alignments
  task automatic t_mux();
    logic [4:0] codes [9] = '{5'h00, 5'h07, 5'h08, 5'h10, 5'h17, 5'h18,
      5'h1d, 5'h1e, 5'h1f};
    logic [15:0] r;
    logic [9:0] p;
    foreach (codes[i])
    begin
      p = pick(codes[i]);
      apb(1'b1, ADCC_IDX_MUX, {3'b000, codes[i]});
      apb(1'b1, ADCC_IDX_CTRL_A, 8'hd0);
      measure();
      result(r);
      chk(r, {6'h00, p});
      apb(1'b1, ADCC_IDX_MUX, {3'b001, codes[i]});
      result(r);
      chk(r, {p, 6'h00});
      apb(1'b0, ADCC_IDX_RES_HIGH, 8'h00);
      chk(rd, p[9:2]);
    end
  endtask

  // changes during a conversion, result lock, abort
  task automatic t_hold();
    logic [15:0] r;
    apb(1'b1, ADCC_IDX_MUX, 8'h21);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'hd0);
    apb(1'b1, ADCC_IDX_MUX, 8'he2);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'h80);
    chk(conversion_active, 1'b1);
    chk(active_reference, 2'b00);
    measure();
    result(r);
    chk(r, {pick(5'h01), 6'h00});
    chk(active_reference, 2'b11);
    apb(1'b0, ADCC_IDX_RES_LOW, 8'h00);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'hd0);
    measure();
    apb(1'b0, ADCC_IDX_RES_HIGH, 8'h00);
    chk(rd, 8'h04);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'hd0);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'h00);
    repeat (2) @(posedge clock);
    chk(conversion_active, 1'b0);
    chk(converter_power, 1'b0);
    apb(1'b0, ADCC_IDX_CTRL_A, 8'h00);
    chk(rd, 8'h00);
  endtask

  // interrupt gating and both ways of clearing the flag
  task automatic t_irq();
    global_irq_enable <= 1'b1;
    apb(1'b1, ADCC_IDX_CTRL_A, 8'hd8);
    measure();
    chk(conversion_irq, 1'b1);
    global_irq_enable <= 1'b0;
    @(posedge clock);
    chk(conversion_irq, 1'b0);
    global_irq_enable <= 1'b1;
    irq_vector_taken <= 1'b1;
    @(posedge clock);
    irq_vector_taken <= 1'b0;
    @(posedge clock);
    chk(conversion_irq, 1'b0);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'hd8);
    measure();
    // whole-value write, never read-modify-write
    apb(1'b1, ADCC_IDX_CTRL_A, 8'h98);
    @(posedge clock);
    chk(conversion_irq, 1'b0);
    apb(1'b0, ADCC_IDX_CTRL_A, 8'h00);
    chk(rd, 8'h88);
  endtask

  // free running, trigger edge, quiet switch to free mode
  task automatic t_auto();
    apb(1'b1, ADCC_IDX_CTRL_B, 8'h00);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'hf0);
    repeat (120) @(posedge clock);
    apb(1'b0, ADCC_IDX_CTRL_A, 8'h00);
    chk(rd & 8'h50, 8'h50);
    chk(conversion_active, 1'b1);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'h00);
    apb(1'b1, ADCC_IDX_CTRL_B, 8'h03);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'ha0);
    trigger_sources[3] <= 1'b1;
    repeat (10) @(posedge clock);
    apb(1'b0, ADCC_IDX_CTRL_A, 8'h00);
    chk(rd & 8'h40, 8'h40);
    measure();
    trigger_sources[3] <= 1'b0;
    apb(1'b1, ADCC_IDX_CTRL_B, 8'h00);
    repeat (40) @(posedge clock);
    chk(conversion_active, 1'b0);
    apb(1'b1, ADCC_IDX_CTRL_A, 8'h00);
  endtask

  // main sequence
  initial
  begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_lengths();
    t_mux();
    t_hold();
    t_irq();
    t_auto();
    finish_test();
  end
endmodule
